// ### dv/aadc_link_chk.sv
/*
  Checker on the converter link pins: trigger, hold, status, byte groups.
  Assumes the bench instantiates it beside the link, 15 bit variant.
*/
`default_nettype none
`include "aadc_regs.svh"

module aadc_link_chk (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic trigger, // start pulse
  input wire logic sh_track, // sample/hold select
  input wire logic status, // converting
  input wire logic upper_byte_output_enable_n, // upper enable
  input wire logic lower_byte_output_enable_n, // lower enable
  input wire logic [7:0] upper_data, // upper byte
  input wire logic [7:0] lower_data, // lower byte
  input wire logic upper_oe, // upper driving
  input wire logic lower_oe // lower driving
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  int stat_cnt;
  int trig_cnt;

  ////////////////////////////////////////////////////////////////////////
  // High-time counters; long repetitions would crawl
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stat_cnt <= 0;
      trig_cnt <= 0;
    end
    else
    begin
      stat_cnt <= status ? stat_cnt + 1 : 0;
      trig_cnt <= trigger ? trig_cnt + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start only after the trigger falls
  a_start_on_fall: assert property ($fell(trigger) |-> ##[1:5] $rose(status))
    else $error("status did not rise after trigger fall");
  a_no_rise_start: assert property ($rose(trigger) |=> !status [*8])
    else $error("status rose on trigger rise");
  // Conversion length: every bit resolved, within the limit
  a_conv_time: assert property ($fell(status) |->
    stat_cnt >= `AADC_RES_W * `AADC_BIT_CYC && stat_cnt <= `AADC_CONV15_CYC)
    else $error("conversion length out of range");
  a_status_bound: assert property (stat_cnt <= `AADC_CONV15_CYC)
    else $error("status high too long");
  a_start_code: assert property ($rose(status) |->
    {upper_data, lower_data} == 16'h3fff)
    else $error("start code not msb low rest high");
  a_hold_in_conv: assert property (status |-> !sh_track)
    else $error("sampling stage tracking during conversion");
  a_trig_width: assert property ($fell(trigger) |->
    trig_cnt >= `AADC_ACQ15_CYC)
    else $error("trigger pulse too short");
  a_trig_tied: assert property (trigger == sh_track)
    else $error("trigger and select apart");
  // Byte groups drive only behind their own enable
  a_upper_oe: assert property
    (upper_oe == !$past(upper_byte_output_enable_n, 2))
    else $error("upper group drive not tied to enable");
  a_lower_oe: assert property
    (lower_oe == !$past(lower_byte_output_enable_n, 2))
    else $error("lower group drive not tied to enable");
  a_data_stable: assert property (!status && !$past(status) |->
    $stable(upper_data) && $stable(lower_data))
    else $error("result moved while idle");
endmodule // aadc_link_chk

`default_nettype wire

// ### dv/tb_acquisition_adc_control.sv
/*
  Bench joining controller and converter across the link; APB stimulus.
  Assumes the 15 bit variant; the front end level is set per test and changed once mid-conversion.
*/
`default_nettype none
`include "aadc_regs.svh"

module tb_acquisition_adc_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic bip; logic twos; logic [14:0] lvl; logic [14:0] exp;}
    aadc_row_s;
  aadc_row_s rows [5] = '{'{1'b0, 1'b0, 15'h5a5a, 15'h5a5a},
    '{1'b0, 1'b1, 15'h0001, 15'h0001}, '{1'b1, 1'b0, 15'h7fff, 15'h7fff},
    '{1'b1, 1'b1, 15'h4000, 15'h0000}, '{1'b1, 1'b1, 15'h0000, 15'h4000}};
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdq;
  logic errq, strap_bipolar, strap_twos_comp;
  logic [14:0] analog_level;
  int n_fail, n_checks, cyc, c;

  aadc_link_if link();
  aadc_device i_aadc_device (.mclk(mclk), .arst_n(arst_n), .clk_en(1'b1),
    .analog_level(analog_level), .strap_bipolar(strap_bipolar),
    .strap_twos_comp(strap_twos_comp), .link(link));
  aadc_controller i_aadc_controller (.mclk(mclk), .arst_n(arst_n),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  aadc_link_chk i_aadc_link_chk (.mclk(mclk), .arst_n(arst_n),
    .trigger(link.trigger), .sh_track(link.sh_track), .status(link.status),
    .upper_byte_output_enable_n(link.upper_byte_output_enable_n),
    .lower_byte_output_enable_n(link.lower_byte_output_enable_n),
    .upper_data(link.upper_data), .lower_data(link.lower_data),
    .upper_oe(link.upper_oe), .lower_oe(link.lower_oe));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a conversion row is about 4500 cycles
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_fail++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; waits for pready, bounded
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check("pready", 1, n < 50);
    rdq = prdata;
    errq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Straps are caught after reset, so each coding gets its own reset
  task automatic do_reset(logic bip, logic twos);
    arst_n <= 1'b0;
    strap_bipolar <= bip;
    strap_twos_comp <= twos;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      apb(0, `AADC_STAT_OFS, 0);
      n++;
    end while (rdq[0] !== 1'b0 && n < 2000);
    check("idle", 1, n < 2000);
    @(negedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {strap_bipolar, strap_twos_comp, analog_level} = '0;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    do_reset(0, 0);
    check("upper_oe", 0, link.upper_oe);
    check("lower_oe", 0, link.lower_oe);
    check("irq", 0, irq);
    apb(0, `AADC_IRQ_MASK_OFS, 0);
    check("mask", 0, rdq);
    // Coding rows: convert, time it, fetch, clear the event
    foreach (rows[i])
    begin
      analog_level <= rows[i].lvl;
      do_reset(rows[i].bip, rows[i].twos);
      apb(1, `AADC_IRQ_MASK_OFS, 1);
      apb(1, `AADC_CTRL_OFS, 1);
      c = 0;
      while (irq !== 1'b1 && c < 8000)
      begin
        @(negedge mclk);
        c++;
      end
      check("cycle_time", 1, c < 6250);
      apb(0, `AADC_DATA_OFS, 0);
      check("result", {17'h0, rows[i].exp}, rdq);
      apb(0, `AADC_STAT_OFS, 0);
      check("stat", 32'h4, rdq);
      apb(1, `AADC_IRQ_STAT_OFS, 1);
      @(negedge mclk);
      check("irq_clr", 0, irq);
    end
    // Level changed and start repeated mid-conversion: held value wins
    analog_level <= 15'h1234;
    do_reset(0, 0);
    apb(1, `AADC_IRQ_MASK_OFS, 7);
    apb(1, `AADC_CTRL_OFS, 1);
    c = 0;
    while (link.status !== 1'b1 && c < 1000)
    begin
      @(negedge mclk);
      c++;
    end
    analog_level <= 15'h7000;
    apb(1, `AADC_CTRL_OFS, 1);
    apb(0, `AADC_IRQ_STAT_OFS, 0);
    check("refused", 2, rdq);
    wait_idle();
    apb(0, `AADC_DATA_OFS, 0);
    check("held", 32'h1234, rdq);
    // Masked event leaves irq low
    apb(1, `AADC_IRQ_STAT_OFS, 7);
    apb(1, `AADC_IRQ_MASK_OFS, 0);
    apb(1, `AADC_CTRL_OFS, 1);
    repeat (700) @(posedge mclk);
    wait_idle();
    check("masked_irq", 0, irq);
    apb(0, `AADC_IRQ_STAT_OFS, 0);
    check("done_bit", 1, rdq);
    apb(0, `AADC_DATA_OFS, 0);
    check("new_result", 32'h7000, rdq);
    // Unmapped address
    apb(0, 8'h14, 0);
    check("slverr", 1, errq);
    check("unmapped", 0, rdq);
    test_done();
  end
endmodule // tb_acquisition_adc_control

`default_nettype wire

// ### rtl/aadc_controller.sv
/*
  Controller end of the acquisition link, run from APB registers.
  Drives the tied trigger and sample/hold select, waits out the converter
  status, then fetches both bytes. Assumes status and bus bytes come from
  another domain and resynchronises them.
*/
`default_nettype none
`include "aadc_regs.svh"

module aadc_controller #(
  parameter bit WIDE_VARIANT = 1'b1,
  parameter int CONV_MAX_CYC = `AADC_CONV15_CYC
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic clk_en, // freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB unmapped address
  output logic irq, // level interrupt
  aadc_link_if.ctl link // pins toward the converter
);
  localparam logic [12:0] ACQ_LAST = WIDE_VARIANT ?
    13'(`AADC_ACQ15_CYC - 1) : 13'(`AADC_ACQ14_CYC - 1);
  localparam logic [12:0] CONV_LIMIT =
    13'(CONV_MAX_CYC + `AADC_SLACK_CYC);

  aadc_pkg::aadc_ctl_state_e state;
  aadc_pkg::aadc_ctl_state_e next_state;
  logic [12:0] timer;
  logic [12:0] next_timer;
  logic [1:0] st_s;
  logic [7:0] hi_s0;
  logic [7:0] hi_s1;
  logic [7:0] lo_s0;
  logic [7:0] lo_s1;
  logic [14:0] result;
  logic valid;
  logic drive_q;
  logic up_en_n_q;
  logic lo_en_n_q;
  logic [`AADC_IRQ_W-1:0] irq_stat;
  logic [`AADC_IRQ_W-1:0] irq_mask;
  logic [`AADC_IRQ_W-1:0] irq_set;
  wire wr;
  wire setup;
  wire hit;
  wire start_req;
  wire timed_out;
  wire rd_done;
  wire [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////
  // APB decode: one wait-free access phase, read data set in setup
  assign wr = psel & penable & pwrite & clk_en;
  assign setup = psel & ~penable & clk_en;
  assign hit = paddr == `AADC_CTRL_OFS || paddr == `AADC_STAT_OFS ||
    paddr == `AADC_DATA_OFS || paddr == `AADC_IRQ_STAT_OFS ||
    paddr == `AADC_IRQ_MASK_OFS;
  assign pready = clk_en;
  assign pslverr = psel & penable & ~hit;
  assign start_req = wr && paddr == `AADC_CTRL_OFS &&
    pwdata[`AADC_CTRL_START];
  assign rd_mux =
    paddr == `AADC_STAT_OFS ? {29'h0, valid, st_s[1],
      state != aadc_pkg::AADC_CTL_IDLE} :
    paddr == `AADC_DATA_OFS ? {17'h0, result} :
    paddr == `AADC_IRQ_STAT_OFS ? {29'h0, irq_stat} :
    paddr == `AADC_IRQ_MASK_OFS ? {29'h0, irq_mask} : 32'h0;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0;
    else if (setup)
      prdata <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  // Resynchronisers for status and both bus bytes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_s <= 2'h0;
      hi_s0 <= 8'h00;
      hi_s1 <= 8'h00;
      lo_s0 <= 8'h00;
      lo_s1 <= 8'h00;
    end
    else if (clk_en)
    begin
      st_s <= {st_s[0], link.status};
      hi_s0 <= link.upper_bus;
      hi_s1 <= hi_s0;
      lo_s0 <= link.lower_bus;
      lo_s1 <= lo_s0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence: acquire, wait for status to rise and fall, read two bytes
  assign timed_out = timer == CONV_LIMIT;
  assign rd_done = timer == `AADC_RD_WAIT;

  always_comb
  begin
    next_state = state;
    next_timer = timer + 13'h0001;
    case (state)
      aadc_pkg::AADC_CTL_IDLE:
      begin
        next_timer = 13'h0000;
        if (start_req)
          next_state = aadc_pkg::AADC_CTL_ACQ;
      end
      aadc_pkg::AADC_CTL_ACQ:
        if (timer == ACQ_LAST)
        begin
          next_state = aadc_pkg::AADC_CTL_ARM;
          next_timer = 13'h0000;
        end
      aadc_pkg::AADC_CTL_ARM:
        if (timed_out)
          next_state = aadc_pkg::AADC_CTL_IDLE;
        else if (st_s[1])
          next_state = aadc_pkg::AADC_CTL_CONV;
      aadc_pkg::AADC_CTL_CONV:
        if (timed_out)
          next_state = aadc_pkg::AADC_CTL_IDLE;
        else if (!st_s[1])
        begin
          next_state = aadc_pkg::AADC_CTL_RD_HI;
          next_timer = 13'h0000;
        end
      aadc_pkg::AADC_CTL_RD_HI:
        if (rd_done)
        begin
          next_state = aadc_pkg::AADC_CTL_RD_LO;
          next_timer = 13'h0000;
        end
      aadc_pkg::AADC_CTL_RD_LO:
        if (rd_done)
          next_state = aadc_pkg::AADC_CTL_IDLE;
      default:
        next_state = aadc_pkg::AADC_CTL_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= aadc_pkg::AADC_CTL_IDLE;
      timer <= 13'h0000;
      drive_q <= 1'b0;
      up_en_n_q <= 1'b1;
      lo_en_n_q <= 1'b1;
    end
    else if (clk_en)
    begin
      state <= next_state;
      timer <= next_timer;
      drive_q <= next_state == aadc_pkg::AADC_CTL_ACQ;
      up_en_n_q <= next_state != aadc_pkg::AADC_CTL_RD_HI;
      lo_en_n_q <= next_state != aadc_pkg::AADC_CTL_RD_LO;
    end
  end

  // One signal serves as trigger and sample/hold select
  assign link.trigger = drive_q;
  assign link.sh_track = drive_q;
  assign link.upper_byte_output_enable_n = up_en_n_q;
  assign link.lower_byte_output_enable_n = lo_en_n_q;

  // Fetched result, latched byte by byte after the enable has settled
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      result <= 15'h0000;
      valid <= 1'b0;
    end
    else if (clk_en && rd_done)
    begin
      if (state == aadc_pkg::AADC_CTL_RD_HI)
        result[14:8] <= hi_s1[6:0];
      else if (state == aadc_pkg::AADC_CTL_RD_LO)
      begin
        result[7:0] <= lo_s1;
        valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; a new event beats the clear
  always_comb
  begin
    irq_set = '0;
    irq_set[`AADC_IRQ_DONE] = rd_done &&
      state == aadc_pkg::AADC_CTL_RD_LO;
    irq_set[`AADC_IRQ_REFUSED] = start_req &&
      state != aadc_pkg::AADC_CTL_IDLE;
    irq_set[`AADC_IRQ_TIMEOUT] = timed_out &&
      (state == aadc_pkg::AADC_CTL_ARM ||
       state == aadc_pkg::AADC_CTL_CONV);
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_stat <= `AADC_IRQ_RESET;
      irq_mask <= `AADC_IRQ_RESET;
    end
    else if (clk_en)
    begin
      if (wr && paddr == `AADC_IRQ_STAT_OFS)
        irq_stat <= (irq_stat & ~pwdata[`AADC_IRQ_W-1:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      if (wr && paddr == `AADC_IRQ_MASK_OFS)
        irq_mask <= pwdata[`AADC_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);
endmodule // aadc_controller

`default_nettype wire

// ### rtl/aadc_device.sv
/*
  Converter end of the acquisition link: trigger and sample/hold inputs,
  a sequenced 14 or 15 bit conversion, status, and two tri-state byte
  groups with their own enables.
  Assumes link pins arrive from another clock domain and are resynchronised
  here; the analog front end is modelled by a digital level on mclk.
*/
// Operation
// - 14 or 15 bit parallel result
// - Positive trigger pulse, start on falling edge
// - Conversion done within 35 or 44 us
// - Cycle sustains 25 or 20 kHz
// - Select high tracks, low holds input
// - Byte group drives only while enabled low
// - Tri-state result in high, low bytes
// - Status high exactly during conversion
// - Binary unipolar, offset or twos bipolar
// - Tied trigger pulse high 4 or 5 us
// - Coding fixed by straps, not runtime
// - Falling edge holds, starts, resets sequencing
// - Start: MSB low, others high, status high
// - One bit per internal tick, MSB first
// - Triggers ignored until conversion ends
`default_nettype none
`include "aadc_regs.svh"

module aadc_device #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, low
  input wire logic clk_en, // freezes all state when low
  input wire logic [`AADC_RES_W-1:0] analog_level, // front end level
  input wire logic strap_bipolar, // jumper: bipolar range
  input wire logic strap_twos_comp, // jumper: twos complement
  aadc_link_if.dev link // pins toward the controller
);
  localparam int RES = WIDE_VARIANT ? 15 : 14;
  localparam logic [7:0] BIT_LAST = 8'(`AADC_BIT_CYC - 1);

  logic [2:0] trig_s;
  logic [1:0] sh_s;
  logic [1:0] up_en_s;
  logic [1:0] lo_en_s;
  logic [1:0] strap_s0;
  logic [1:0] strap_s1;
  logic [1:0] strap_cnt;
  logic coding_bip;
  logic coding_twos;
  aadc_pkg::aadc_dev_state_e state;
  aadc_pkg::aadc_dev_state_e next_state;
  logic [7:0] tick_cnt;
  logic [`AADC_RES_W-1:0] held;
  logic [`AADC_RES_W-1:0] out_word;
  logic status_q;
  logic [`AADC_RES_W-1:0] code;
  logic last;
  wire trig_fall;
  wire start;
  wire tick;
  wire done;
  wire converting;
  wire flip_msb;
  wire [`AADC_RES_W-1:0] msb_mask;
  wire [`AADC_RES_W-1:0] coded;
  wire [`AADC_RES_W-1:0] level_masked;

  ////////////////////////////////////////////////////////////////////////
  // Pin resynchronisers; first stages feed only their second stages
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      trig_s <= 3'h0;
      sh_s <= 2'h0;
      up_en_s <= 2'h3;
      lo_en_s <= 2'h3;
      strap_s0 <= 2'h0;
      strap_s1 <= 2'h0;
    end
    else if (clk_en)
    begin
      trig_s <= {trig_s[1:0], link.trigger};
      sh_s <= {sh_s[0], link.sh_track};
      up_en_s <= {up_en_s[0], link.upper_byte_output_enable_n};
      lo_en_s <= {lo_en_s[0], link.lower_byte_output_enable_n};
      strap_s0 <= {strap_bipolar, strap_twos_comp};
      strap_s1 <= strap_s0;
    end
  end

  // Straps caught once after reset release; later jumper moves ignored
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt <= 2'h0;
      coding_bip <= 1'b0;
      coding_twos <= 1'b0;
    end
    else if (clk_en && strap_cnt != 2'h3)
    begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2)
      begin
        coding_bip <= strap_s1[1];
        coding_twos <= strap_s1[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start only on the falling edge, and only while idle
  assign trig_fall = trig_s[2] & ~trig_s[1];
  // Status lags the state by one edge; a start waits until it is down
  assign start = trig_fall && !status_q &&
    state == aadc_pkg::AADC_DEV_IDLE;
  assign converting = state == aadc_pkg::AADC_DEV_CONV;
  assign tick = state == aadc_pkg::AADC_DEV_CONV && tick_cnt == BIT_LAST;
  assign done = tick && last;

  // Sequencer: idle until a start, convert until the last bit
  always_comb
  begin
    next_state = state;
    case (state)
      aadc_pkg::AADC_DEV_IDLE:
        if (start)
          next_state = aadc_pkg::AADC_DEV_CONV;
      aadc_pkg::AADC_DEV_CONV:
        if (done)
          next_state = aadc_pkg::AADC_DEV_IDLE;
      default:
        next_state = aadc_pkg::AADC_DEV_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state <= aadc_pkg::AADC_DEV_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // Internal clock divider, cleared on every start
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      tick_cnt <= 8'h00;
    else if (clk_en)
    begin
      if (start || tick || state != aadc_pkg::AADC_DEV_CONV)
        tick_cnt <= 8'h00;
      else
        tick_cnt <= tick_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample/hold: tracks while select is high, frozen while low or busy
  assign level_masked = analog_level & {`AADC_RES_W{1'b1}} >> (15 - RES);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      held <= '0;
    else if (clk_en && sh_s[1] && !start &&
             state == aadc_pkg::AADC_DEV_IDLE)
      held <= level_masked;
  end

  aadc_sar #(
    .RES(RES)
  ) i_aadc_sar (
    .clk(mclk),
    .arst_n(arst_n),
    .ce(clk_en),
    .start(start),
    .step(tick),
    .held(held),
    .code(code),
    .last(last)
  );

  ////////////////////////////////////////////////////////////////////////
  // Output coding; two's complement only flips the MSB, and only on the
  // final code, so the start pattern reaches the pins unchanged
  assign msb_mask = `AADC_RES_W'(1) << (RES - 1);
  assign flip_msb = coding_bip & coding_twos;
  assign coded = (flip_msb && !converting) ? code ^ msb_mask : code;

  // Result and status move together; outside a conversion the word holds
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_word <= '0;
      status_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (converting || status_q)
        out_word <= coded;
      status_q <= converting;
    end
  end

  assign link.status = status_q;

  // Byte groups: right justified result split high and low
  assign link.upper_data = {1'b0, out_word[14:8]};
  assign link.lower_data = out_word[7:0];
  assign link.upper_oe = ~up_en_s[1];
  assign link.lower_oe = ~lo_en_s[1];
endmodule // aadc_device

`default_nettype wire

// ### rtl/aadc_link_if.sv
/*
  Pin bundle between the converter and its controller.
  Resolves the two tri-state byte groups from each data and enable pair;
  the testbench instantiates it and joins both ends.
*/
`default_nettype none

interface aadc_link_if;
  logic trigger;
  logic sh_track;
  logic status;
  logic upper_byte_output_enable_n;
  logic lower_byte_output_enable_n;
  logic [7:0] upper_data;
  logic [7:0] lower_data;
  logic upper_oe;
  logic lower_oe;
  wire [7:0] upper_bus;
  wire [7:0] lower_bus;

  // Released groups show the inverse, so an early fetch reads wrong
  assign upper_bus = upper_oe ? upper_data : ~upper_data;
  assign lower_bus = lower_oe ? lower_data : ~lower_data;

  modport dev (
    input trigger, sh_track,
    input upper_byte_output_enable_n, lower_byte_output_enable_n,
    output status, upper_data, lower_data, upper_oe, lower_oe
  );
  modport ctl (
    output trigger, sh_track,
    output upper_byte_output_enable_n, lower_byte_output_enable_n,
    input status, upper_bus, lower_bus
  );
endinterface

`default_nettype wire

// ### rtl/aadc_pkg.sv
/*
  Types shared by both ends of the acquisition converter link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package aadc_pkg;
  // Converter end sequencing
  typedef enum logic [0:0] {AADC_DEV_IDLE, AADC_DEV_CONV} aadc_dev_state_e;
  // Controller end sequencing
  typedef enum logic [2:0] {
    AADC_CTL_IDLE, AADC_CTL_ACQ, AADC_CTL_ARM,
    AADC_CTL_CONV, AADC_CTL_RD_HI, AADC_CTL_RD_LO
  } aadc_ctl_state_e;
endpackage

`default_nettype wire

// ### rtl/aadc_regs.svh
/*
  Constants of the acquisition converter link and its controller: timing
  counts at the 125 MHz mclk, controller register offsets and bit fields.
  Assumes it is included by bare name wherever a count or offset is used.
*/
`ifndef AADC_REGS_SVH
`define AADC_REGS_SVH

// Clock and converter timing
`define AADC_CLK_MHZ 125
`define AADC_RES_W 15
`define AADC_BIT_NS 2000
`define AADC_BIT_CYC ((`AADC_BIT_NS * `AADC_CLK_MHZ) / 1000)
`define AADC_CONV14_NS 35000
`define AADC_CONV15_NS 44000
`define AADC_CONV14_CYC ((`AADC_CONV14_NS * `AADC_CLK_MHZ) / 1000)
`define AADC_CONV15_CYC ((`AADC_CONV15_NS * `AADC_CLK_MHZ) / 1000)
`define AADC_ACQ14_NS 4000
`define AADC_ACQ15_NS 5000
`define AADC_ACQ14_CYC ((`AADC_ACQ14_NS * `AADC_CLK_MHZ + 999) / 1000)
`define AADC_ACQ15_CYC ((`AADC_ACQ15_NS * `AADC_CLK_MHZ + 999) / 1000)
`define AADC_SLACK_CYC 16
`define AADC_RD_WAIT 13'h0006

// Controller register map
`define AADC_CTRL_OFS 8'h00
`define AADC_STAT_OFS 8'h04
`define AADC_DATA_OFS 8'h08
`define AADC_IRQ_STAT_OFS 8'h0c
`define AADC_IRQ_MASK_OFS 8'h10
`define AADC_CTRL_START 0
`define AADC_STAT_BUSY 0
`define AADC_STAT_LINK 1
`define AADC_STAT_VALID 2
`define AADC_IRQ_DONE 0
`define AADC_IRQ_REFUSED 1
`define AADC_IRQ_TIMEOUT 2
`define AADC_IRQ_W 3
`define AADC_IRQ_RESET 3'h0

`endif

// ### rtl/aadc_sar.sv
/*
  Successive approximation register of the converter end.
  Assumes start and step come from the converter sequencer on mclk and
  that the held level is right justified in RES bits.
*/
`default_nettype none
`include "aadc_regs.svh"

module aadc_sar #(
  parameter int RES = 15
) (
  input wire logic clk, // mclk
  input wire logic arst_n, // async reset, low
  input wire logic ce, // clock enable
  input wire logic start, // conversion begins
  input wire logic step, // one internal clock tick
  input wire logic [`AADC_RES_W-1:0] held, // frozen input level
  output logic [`AADC_RES_W-1:0] code, // partial or final code
  output logic last // deciding the final bit
);
  logic [3:0] idx;
  logic [`AADC_RES_W-1:0] trial;
  logic [`AADC_RES_W-1:0] init;
  wire decide;

  // Per bit: trial word and start pattern, MSB low and the rest high
  for (genvar i = 0; i < `AADC_RES_W; i++)
  begin : g_bit
    assign trial[i] = (i >= RES) ? 1'b0 :
      (4'(i) > idx) ? code[i] : (4'(i) == idx);
    assign init[i] = (i < RES - 1);
  end

  // One comparison of the trial word per tick
  assign decide = held >= trial;
  assign last = idx == 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Bit resolution from the MSB down, one bit per tick
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      code <= '0;
      idx <= 4'h0;
    end
    else if (ce && start)
    begin
      code <= init;
      idx <= 4'(RES - 1);
    end
    else if (ce && step)
    begin
      code[idx] <= decide;
      idx <= idx - 4'h1;
    end
  end
endmodule // aadc_sar

`default_nettype wire
